/* design/itr_pkg.sv */
package itr_pkg;

	// ------------------------------------------------------------
	// addressing and register file
	// ------------------------------------------------------------
	localparam logic [6:0] ITR_ADDR_DEFAULT = 7'h4f;
	localparam int ITR_REG_DEPTH = 256;
	localparam logic [7:0] ITR_PTR_RESET = 8'h00;
	localparam logic [7:0] ITR_REG_RESET = 8'h00;
	localparam logic [7:0] ITR_DRV_OFS = 8'hf0;
	localparam int ITR_DRV_W = 2;
	localparam logic [ITR_DRV_W-1:0] ITR_DRV_RESET = 2'h3;

	// ------------------------------------------------------------
	// bit framing
	// ------------------------------------------------------------
	localparam logic [2:0] ITR_BIT_LAST = 3'h7;
	localparam logic [3:0] ITR_ACK_SLOT = 4'h8;
	localparam logic [1:0] ITR_Q_DRIVE = 2'h0;
	localparam logic [1:0] ITR_Q_RISE = 2'h1;
	localparam logic [1:0] ITR_Q_SAMPLE = 2'h2;
	localparam logic [1:0] ITR_Q_FALL = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int ITR_CLK_NS = 100;
	localparam int ITR_SCL_PERIOD_NS = 1600;
	localparam int ITR_SCL_QTR_CYC = (ITR_SCL_PERIOD_NS / (4 * ITR_CLK_NS) < 1) ? 1 :
		ITR_SCL_PERIOD_NS / (4 * ITR_CLK_NS);
	localparam logic [7:0] ITR_SCL_QTR = 8'(ITR_SCL_QTR_CYC);

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		T_IDLE, T_ADDR, T_AACK, T_OFS, T_OACK, T_WDATA, T_WACK, T_RDATA, T_RACK, T_WAIT, T_IGNORE
	} itr_tgt_state_t;

	typedef enum logic [2:0] {C_IDLE, C_START, C_TX, C_RX, C_STOP} itr_ctl_state_t;

	typedef enum logic [1:0] {ROLE_ADDR, ROLE_OFS, ROLE_DATA} itr_role_t;

endpackage : itr_pkg

/* design/itr_bus_if.sv */
`timescale 1ns/100ps
interface itr_bus_if
	import itr_pkg::*;
();
	logic scl;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	logic sda_tgt_o;
	logic sda_tgt_oe;
	logic [ITR_DRV_W-1:0] sda_drv;
	logic sda;

	// wired-and of both open-drain drivers with pullup
	assign sda = (~sda_ctl_oe | sda_ctl_o) & (~sda_tgt_oe | sda_tgt_o);

	modport tgt(input scl, input sda, output sda_tgt_o, output sda_tgt_oe, output sda_drv);
	modport ctl(output scl, output sda_ctl_o, output sda_ctl_oe, input sda);

endinterface : itr_bus_if

/* design/itr_controller.sv */
`timescale 1ns/100ps
module itr_controller
	import itr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// serial bus
	itr_bus_if.ctl bus,
	// request
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic req_use_ofs,
	input wire logic [6:0] req_addr,
	input wire logic [7:0] req_ofs,
	input wire logic [7:0] req_count,
	input wire logic [7:0] req_wdata,
	output logic req_ready_q,
	output logic wdata_take_q,
	// answer
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	output logic done_q,
	output logic nack_q
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	itr_ctl_state_t st_q, st_d;
	itr_role_t role_q, role_d;
	logic [7:0] div_q, div_d;
	logic [1:0] qtr_q, qtr_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic scl_q, scl_d;
	logic oe_q, oe_d;
	logic dir_q, dir_d;
	logic rd_q, rd_d;
	logic [7:0] left_q, left_d;
	logic [7:0] ofs_q, ofs_d;
	logic [6:0] addr_q, addr_d;
	logic req_ready_d, wdata_take_d, rd_valid_d, done_d, nack_d;
	logic [7:0] rd_data_d;
	logic sda_s1, sda_s;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic tick = div_q == ITR_SCL_QTR - 8'h01;
	wire logic q_drive = qtr_q == ITR_Q_DRIVE;
	wire logic q_rise = qtr_q == ITR_Q_RISE;
	wire logic q_sample = qtr_q == ITR_Q_SAMPLE;
	wire logic q_fall = qtr_q == ITR_Q_FALL;
	wire logic ack_slot = bit_q == ITR_ACK_SLOT;
	wire logic more = left_q != 8'h00;
	wire logic rx_last = left_q == 8'h01;

	assign bus.scl = scl_q;
	assign bus.sda_ctl_oe = oe_q;
	assign bus.sda_ctl_o = 1'b0;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		role_d = role_q;
		qtr_d = qtr_q;
		bit_d = bit_q;
		sh_d = sh_q;
		scl_d = scl_q;
		oe_d = oe_q;
		dir_d = dir_q;
		rd_d = rd_q;
		left_d = left_q;
		ofs_d = ofs_q;
		addr_d = addr_q;
		req_ready_d = req_ready_q;
		wdata_take_d = 1'b0;
		rd_valid_d = 1'b0;
		rd_data_d = rd_data_q;
		done_d = 1'b0;
		nack_d = nack_q;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		if (st_q == C_IDLE) begin
			req_ready_d = 1'b1;
			if (req_valid && req_ready_q) begin
				req_ready_d = 1'b0;
				st_d = C_START;
				qtr_d = ITR_Q_DRIVE;
				div_d = 8'h00;
				rd_d = req_read;
				ofs_d = req_ofs;
				addr_d = req_addr;
				dir_d = req_read & ~req_use_ofs;
				sh_d = {req_addr, req_read & ~req_use_ofs};
				role_d = ROLE_ADDR;
				left_d = (req_read && req_count == 8'h00) ? 8'h01 : req_count;
				nack_d = 1'b0;
			end
		end else if (tick) begin
			qtr_d = qtr_q + 2'h1;
			case (st_q)
				C_START: begin
					if (q_drive) oe_d = 1'b0;
					if (q_rise) scl_d = 1'b1;
					if (q_sample) oe_d = 1'b1;
					if (q_fall) begin
						scl_d = 1'b0;
						st_d = C_TX;
						bit_d = 4'h0;
					end
				end
				C_TX: begin
					if (q_drive) oe_d = ack_slot ? 1'b0 : ~sh_q[7];
					if (q_rise) scl_d = 1'b1;
					if (q_sample && ack_slot) nack_d = sda_s;
					if (q_fall) begin
						scl_d = 1'b0;
						bit_d = ack_slot ? 4'h0 : bit_q + 4'h1;
						if (!ack_slot) begin
							sh_d = {sh_q[6:0], 1'b0};
						end else if (nack_q) begin
							st_d = C_STOP;
						end else if (role_q == ROLE_ADDR && dir_q) begin
							st_d = C_RX;
						end else if (role_q == ROLE_ADDR) begin
							sh_d = ofs_q;
							role_d = ROLE_OFS;
						end else if (role_q == ROLE_OFS && rd_q) begin
							st_d = C_START;
							sh_d = {addr_q, 1'b1};
							dir_d = 1'b1;
							role_d = ROLE_ADDR;
						end else if (more) begin
							sh_d = req_wdata;
							wdata_take_d = 1'b1;
							left_d = left_q - 8'h01;
							role_d = ROLE_DATA;
						end else begin
							st_d = C_STOP;
						end
					end
				end
				C_RX: begin
					if (q_drive) oe_d = ack_slot & ~rx_last;
					if (q_rise) scl_d = 1'b1;
					if (q_sample && !ack_slot) sh_d = {sh_q[6:0], sda_s};
					if (q_fall) begin
						scl_d = 1'b0;
						bit_d = ack_slot ? 4'h0 : bit_q + 4'h1;
						if (bit_q == {1'b0, ITR_BIT_LAST}) begin
							rd_data_d = sh_q;
							rd_valid_d = 1'b1;
						end
						if (ack_slot) begin
							left_d = left_q - 8'h01;
							if (rx_last) st_d = C_STOP;
						end
					end
				end
				C_STOP: begin
					if (q_drive) oe_d = 1'b1;
					if (q_rise) scl_d = 1'b1;
					if (q_sample) oe_d = 1'b0;
					if (q_fall) begin
						st_d = C_IDLE;
						done_d = 1'b1;
					end
				end
				default: st_d = C_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_s1 <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_s1 <= bus.sda;
			sda_s <= sda_s1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= C_IDLE;
			role_q <= ROLE_ADDR;
			div_q <= 8'h00;
			qtr_q <= ITR_Q_DRIVE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			dir_q <= 1'b0;
			rd_q <= 1'b0;
			left_q <= 8'h00;
			ofs_q <= 8'h00;
			addr_q <= 7'h00;
		end else begin
			st_q <= st_d;
			role_q <= role_d;
			div_q <= div_d;
			qtr_q <= qtr_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			scl_q <= scl_d;
			oe_q <= oe_d;
			dir_q <= dir_d;
			rd_q <= rd_d;
			left_q <= left_d;
			ofs_q <= ofs_d;
			addr_q <= addr_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_ready_q <= 1'b1;
			wdata_take_q <= 1'b0;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			req_ready_q <= req_ready_d;
			wdata_take_q <= wdata_take_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			done_q <= done_d;
			nack_q <= nack_d;
		end
	end

endmodule : itr_controller

/* design/itr_target.sv */
`timescale 1ns/100ps
// Behaviour
// - answer at address 4f, bytes 9e/9f
// - controller starts, sends address with write bit
// - acknowledge matching write address byte
// - controller sends offset byte, msb first
// - acknowledge offset, load it as pointer
// - store first data byte, acknowledge it
// - acknowledge every further data byte
// - controller ends write with stop
// - register defaults work without any access
// - match against factory-programmed address value
// - data line drive strength set by register
// - reads start at pointer: zero, next, offset
// - send on ack, stop on nack
// - read pointer advances even without ack
// - offset-only write sets pointer, writes nothing
module itr_target
	import itr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// serial bus
	itr_bus_if.tgt bus,
	// factory address storage
	input wire logic [6:0] otp_addr,
	// register write report
	output logic wr_stb_q,
	output logic [7:0] wr_ofs_q,
	output logic [7:0] wr_data_q,
	// drive strength selection
	output logic [ITR_DRV_W-1:0] drv_sel_q
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	itr_tgt_state_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic oe_q, oe_d;
	logic rd_q, rd_d;
	logic [6:0] addr_q;
	logic addr_loaded_q;
	logic wr_en;
	logic [7:0] regs [ITR_REG_DEPTH];
	logic scl_s1, scl_s, scl_p;
	logic sda_s1, sda_s, sda_p;

	// ------------------------------------------------------------
	// reset contents
	// ------------------------------------------------------------
	function automatic logic [7:0] itr_reset_val(input int idx);
		itr_reset_val = (8'(idx) == ITR_DRV_OFS) ? {{(8 - ITR_DRV_W){1'b0}}, ITR_DRV_RESET} : ITR_REG_RESET;
	endfunction : itr_reset_val

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic scl_rise = scl_s & ~scl_p;
	wire logic scl_fall = ~scl_s & scl_p;
	wire logic start_det = scl_s & scl_p & sda_p & ~sda_s;
	wire logic stop_det = scl_s & scl_p & ~sda_p & sda_s;
	wire logic [7:0] rx_byte = {sh_q[6:0], sda_s};
	wire logic byte_end = cnt_q == ITR_BIT_LAST;
	wire logic addr_hit = rx_byte[7:1] == addr_q;
	wire logic [7:0] rd_word = regs[ptr_q];
	wire logic in_ack = st_q == T_AACK || st_q == T_OACK || st_q == T_WACK;

	assign bus.sda_tgt_oe = oe_q;
	assign bus.sda_tgt_o = 1'b0;
	assign bus.sda_drv = drv_sel_q;

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		rd_d = rd_q;
		wr_en = 1'b0;
		if (stop_det) begin
			st_d = T_IDLE;
			oe_d = 1'b0;
		end else if (start_det) begin
			st_d = T_ADDR;
			cnt_d = 3'h0;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			case (st_q)
				T_ADDR, T_OFS, T_WDATA: begin
					sh_d = rx_byte;
					cnt_d = cnt_q + 3'h1;
					if (byte_end && st_q == T_ADDR) begin
						rd_d = rx_byte[0];
						st_d = addr_hit ? T_AACK : T_IGNORE;
					end else if (byte_end && st_q == T_OFS) begin
						ptr_d = rx_byte;
						st_d = T_OACK;
					end else if (byte_end) begin
						wr_en = 1'b1;
						ptr_d = ptr_q + 8'h01;
						st_d = T_WACK;
					end
				end
				T_RDATA: begin
					sh_d = {sh_q[6:0], 1'b0};
					cnt_d = cnt_q + 3'h1;
					if (byte_end) begin
						ptr_d = ptr_q + 8'h01;
						st_d = T_RACK;
					end
				end
				T_RACK: begin
					if (!sda_s) begin
						sh_d = rd_word;
						cnt_d = 3'h0;
						st_d = T_RDATA;
					end else begin
						st_d = T_WAIT;
					end
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			if (in_ack && !oe_q) begin
				oe_d = 1'b1;
			end else if (in_ack && st_q == T_AACK && rd_q) begin
				sh_d = rd_word;
				oe_d = ~rd_word[7];
				cnt_d = 3'h0;
				st_d = T_RDATA;
			end else if (in_ack) begin
				oe_d = 1'b0;
				cnt_d = 3'h0;
				st_d = (st_q == T_AACK) ? T_OFS : T_WDATA;
			end else if (st_q == T_RDATA) begin
				oe_d = ~sh_q[7];
			end else if (st_q == T_RACK) begin
				oe_d = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// bus input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_s1 <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s1 <= bus.scl;
			scl_s <= scl_s1;
			scl_p <= scl_s;
			sda_s1 <= bus.sda;
			sda_s <= sda_s1;
			sda_p <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// engine registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= T_IDLE;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			ptr_q <= ITR_PTR_RESET;
			oe_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			rd_q <= rd_d;
		end
	end

	// ------------------------------------------------------------
	// factory address capture after reset release
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= ITR_ADDR_DEFAULT;
			addr_loaded_q <= 1'b0;
		end else if (!addr_loaded_q) begin
			addr_q <= otp_addr;
			addr_loaded_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < ITR_REG_DEPTH; i++) begin
				regs[i] <= itr_reset_val(i);
			end
		end else if (wr_en) begin
			regs[ptr_q] <= rx_byte;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_stb_q <= 1'b0;
			wr_ofs_q <= 8'h00;
			wr_data_q <= 8'h00;
			drv_sel_q <= ITR_DRV_RESET;
		end else begin
			wr_stb_q <= wr_en;
			wr_ofs_q <= wr_en ? ptr_q : wr_ofs_q;
			wr_data_q <= wr_en ? rx_byte : wr_data_q;
			drv_sel_q <= regs[ITR_DRV_OFS][ITR_DRV_W-1:0];
		end
	end

endmodule : itr_target

/* sim/itr_bus_checker.sv */
`timescale 1ns/100ps
module itr_bus_checker
	import itr_pkg::*;
(
	// clock and reset
	input logic clk,
	input logic resetn,
	// bus wires
	input logic scl,
	input logic sda_ctl_o,
	input logic sda_ctl_oe,
	input logic sda_tgt_o,
	input logic sda_tgt_oe,
	input logic [ITR_DRV_W-1:0] sda_drv,
	input logic sda
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	property p_reset_idle;
		$rose(resetn) |-> scl && !sda_tgt_oe && !sda_ctl_oe && sda_drv == ITR_DRV_RESET;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
	property p_scl_high;
		$rose(scl) |-> scl [*8];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high phase short");
	property p_scl_low;
		$fell(scl) |-> !scl [*8];
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low phase short");
	property p_start;
		s_start |-> (scl && !sda) [*4] ##1 !scl;
	endproperty
	a_start: assert property (p_start) else $error("start condition malformed");
	property p_stop;
		s_stop |-> (scl && sda) [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("bus not idle after stop");
	property p_ack_hold;
		$rose(scl) && sda_tgt_oe |-> sda_tgt_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("target drive dropped while clock high");
	property p_tgt_low;
		$changed(sda_tgt_oe) |-> !scl && !$past(scl) && !$past(scl, 2);
	endproperty
	a_tgt_low: assert property (p_tgt_low) else $error("target drive changed near clock high");
	property p_drv_quiet;
		$changed(sda_drv) |-> scl && !sda_tgt_oe;
	endproperty
	a_drv_quiet: assert property (p_drv_quiet) else $error("drive strength changed outside data bit");
endmodule : itr_bus_checker

/* sim/i2c_target_register_port_tb.sv */
`timescale 1ns/100ps
module i2c_target_register_port_tb
	import itr_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [6:0] otp_addr = ITR_ADDR_DEFAULT;
	logic req_valid = 1'b0;
	logic req_read = 1'b0;
	logic req_use_ofs = 1'b0;
	logic [6:0] req_addr = 7'h00;
	logic [7:0] req_ofs = 8'h00;
	logic [7:0] req_count = 8'h00;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready_q, wdata_take_q, rd_valid_q, done_q, nack_q, wr_stb_q;
	logic [7:0] rd_data_q, wr_ofs_q, wr_data_q, sh, abyte;
	logic [ITR_DRV_W-1:0] drv_sel_q;
	logic sda_p, scl_p;
	int bc = 0;
	int err_total = 0;
	int num_checks = 0;
	int nr;
	logic [7:0] wbuf [8];
	logic [7:0] rbuf [8];
	logic [15:0] wq [$];
	itr_bus_if bus_a ();
	always #50 clk = ~clk;
	itr_target u_itr_target (.clk(clk), .resetn(resetn), .bus(bus_a.tgt), .otp_addr(otp_addr),
		.wr_stb_q(wr_stb_q), .wr_ofs_q(wr_ofs_q), .wr_data_q(wr_data_q), .drv_sel_q(drv_sel_q));
	itr_controller u_itr_controller (.clk(clk), .resetn(resetn), .bus(bus_a.ctl), .req_valid(req_valid),
		.req_read(req_read), .req_use_ofs(req_use_ofs), .req_addr(req_addr), .req_ofs(req_ofs),
		.req_count(req_count), .req_wdata(req_wdata), .req_ready_q(req_ready_q), .wdata_take_q(wdata_take_q),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .done_q(done_q), .nack_q(nack_q));
	itr_bus_checker u_itr_bus_checker (.clk(clk), .resetn(resetn), .scl(bus_a.scl), .sda_ctl_o(bus_a.sda_ctl_o),
		.sda_ctl_oe(bus_a.sda_ctl_oe), .sda_tgt_o(bus_a.sda_tgt_o), .sda_tgt_oe(bus_a.sda_tgt_oe),
		.sda_drv(bus_a.sda_drv), .sda(bus_a.sda));
	// ------------------------------------------------------------
	// wire and write monitors
	// ------------------------------------------------------------
	always @(posedge clk) begin
		sda_p <= bus_a.sda;
		scl_p <= bus_a.scl;
		if (wr_stb_q === 1'b1) wq.push_back({wr_ofs_q, wr_data_q});
		if (scl_p && bus_a.scl && sda_p && !bus_a.sda) bc <= 0;
		else if (!scl_p && bus_a.scl) begin
			sh <= {sh[6:0], bus_a.sda};
			bc <= bc + 1;
			if (bc == 7) abyte <= {sh[6:0], bus_a.sda};
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk_b(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk_b
	task automatic chk_n(input string n, input int e, input int g);
		num_checks++;
		if (g != e) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_n
	task automatic give_verdict();
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic do_reset(input logic [6:0] ot);
		@(posedge clk);
		otp_addr <= ot;
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	task automatic xfer(input logic rd, input logic uo, input logic [6:0] a, input logic [7:0] o, input int n);
		int t;
		int w;
		t = 0;
		w = 0;
		nr = 0;
		wq.delete();
		while (req_ready_q !== 1'b1) @(posedge clk);
		req_read <= rd;
		req_use_ofs <= uo;
		req_addr <= a;
		req_ofs <= o;
		req_count <= 8'(n);
		req_wdata <= wbuf[0];
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		do begin
			@(posedge clk);
			w++;
			if (wdata_take_q === 1'b1) begin
				t++;
				req_wdata <= wbuf[t % 8];
			end
			if (rd_valid_q === 1'b1) begin
				rbuf[nr % 8] = rd_data_q;
				nr++;
			end
		end while (done_q !== 1'b1 && w < 3000);
		chk_n("transfer cycles", 1, int'(w < 3000));
		@(posedge clk);
	endtask : xfer
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_boot();
		chk_b("drive select", 8'h03, {6'h00, drv_sel_q});
		xfer(1'b1, 1'b0, ITR_ADDR_DEFAULT, 8'h00, 2);
		chk_b("read address byte", 8'h9f, abyte);
		chk_b("boot read 0", 8'h00, rbuf[0]);
		chk_b("boot read 1", 8'h00, rbuf[1]);
	endtask : t_boot
	task automatic t_burst();
		for (int i = 0; i < 4; i++) wbuf[i] = 8'ha1 + 8'(i);
		xfer(1'b0, 1'b0, ITR_ADDR_DEFAULT, 8'h10, 4);
		chk_b("write address byte", 8'h9e, abyte);
		chk_b("write nack", 8'h00, {7'h00, nack_q});
		chk_n("write count", 4, wq.size());
		for (int i = 0; i < 4; i++) chk_b("write pair", 8'h10 + 8'(i), wq[i][15:8]);
		for (int i = 0; i < 4; i++) chk_b("write data", 8'ha1 + 8'(i), wq[i][7:0]);
	endtask : t_burst
	task automatic t_reads();
		xfer(1'b1, 1'b1, ITR_ADDR_DEFAULT, 8'h10, 3);
		chk_n("read count", 3, nr);
		for (int i = 0; i < 3; i++) chk_b("offset read", 8'ha1 + 8'(i), rbuf[i]);
		xfer(1'b1, 1'b0, ITR_ADDR_DEFAULT, 8'h00, 1);
		chk_b("next read", 8'ha4, rbuf[0]);
	endtask : t_reads
	task automatic t_ofs_only();
		xfer(1'b0, 1'b0, ITR_ADDR_DEFAULT, 8'h11, 0);
		chk_n("offset only writes", 0, wq.size());
		chk_b("offset only nack", 8'h00, {7'h00, nack_q});
		xfer(1'b1, 1'b0, ITR_ADDR_DEFAULT, 8'h00, 0);
		chk_n("pointer read count", 1, nr);
		chk_b("pointer read", 8'ha2, rbuf[0]);
	endtask : t_ofs_only
	task automatic t_drv();
		wbuf[0] = 8'h01;
		xfer(1'b0, 1'b0, ITR_ADDR_DEFAULT, ITR_DRV_OFS, 1);
		chk_b("drive select", 8'h01, {6'h00, drv_sel_q});
		chk_b("bus drive", 8'h01, {6'h00, bus_a.sda_drv});
	endtask : t_drv
	task automatic t_otp();
		do_reset(7'h2a);
		wbuf[0] = 8'h5c;
		xfer(1'b0, 1'b0, ITR_ADDR_DEFAULT, 8'h10, 1);
		chk_b("foreign nack", 8'h01, {7'h00, nack_q});
		chk_n("foreign writes", 0, wq.size());
		xfer(1'b1, 1'b1, 7'h2a, ITR_DRV_OFS, 1);
		chk_b("factory address nack", 8'h00, {7'h00, nack_q});
		chk_b("drive default", 8'h03, rbuf[0]);
		xfer(1'b0, 1'b0, 7'h2a, 8'h10, 1);
		chk_n("factory address writes", 1, wq.size());
	endtask : t_otp
	initial begin
		do_reset(ITR_ADDR_DEFAULT);
		t_boot();
		t_burst();
		t_reads();
		t_ofs_only();
		t_drv();
		t_otp();
		give_verdict();
	end
	initial begin
		#4000000;
		err_total++;
		give_verdict();
	end
endmodule : i2c_target_register_port_tb
